// ===== rtl/gpio_defs.vh
// Constants for the dual-port GPIO block with sleep wake-up
// How it works
// - Port reads return live pin levels, never the output latches
// - Every reset forces all direction bits to one, pins become inputs
// - First port has four pins; bits 7-4 read as zero
// - Supply level select bit picks 3 V or 5 V for first port
// - Second port has eight pins, one per data bit
// - Entering sleep captures the four low wake pin levels as reference
// - In sleep, enabled wake pin differing from reference requests reset
// - Pin-change wake clears wake flag; power-on/external/watchdog set it
// - One config bit enables or disables wake-on-change
// - Power-on sets all six config bits; set disable bit keeps wake off
// - Top second-port pin, set as input, wakes the device whenever it is high in sleep with wake enabled
// - Only pins set as inputs can cause a wake-up
// - Direction registers load from accumulator on direction-load only
// - Direction 1 means driver off; 0 drives the output latch
// - Output latches hold until rewritten; inputs are not latched
// - Each pin direction is independently selectable
// - Bit set/clear read pins, modify bit, write whole latch
// - Data latches kept across external, watchdog and wake resets
`ifndef GPIO_DEFS_VH
`define GPIO_DEFS_VH

// ****************************************
// Register file addresses
// ****************************************
`define ADDR_CPU_FLAGS 5'h03
`define ADDR_GROUP_A 5'h05
`define ADDR_GROUP_B 5'h06
// Direction-load targets
`define DIR_SEL_A 3'h5
`define DIR_SEL_B 3'h6
`define DIR_SEL_CFG 3'h7

// ****************************************
// Field positions and reset values
// ****************************************
`define FLAG_WAKE_BIT 7
`define CFG_WAKE_DIS_BIT 5
`define CFG_SUPPLY_BIT 3
`define CFG_RESET 6'h3f
`define DIR_RESET 8'hff
`define GROUP_A_MASK 8'h0f
`define WAKE_LOW_MASK 8'h0f
`define SLOW_PIN_BIT 7

// ****************************************
// Reset causes
// ****************************************
`define RST_POWER_ON 2'h0
`define RST_EXT_WDT 2'h1
`define RST_PIN_WAKE 2'h2
`define RST_BROWN_OUT 2'h3

`endif

// ===== rtl/gpio_port.v
// Dual-port GPIO with direction registers and sleep wake-on-change
`timescale 1ns/1ps
`default_nettype none
`include "gpio_defs.vh"

module gpio_port #(
    parameter A_WIDTH = 4,
    parameter B_WIDTH = 8
) (
    input wire i_sys_clk,
    input wire i_arst_n,
    // Reset cause, sampled while a soft reset pulse is high
    input wire i_soft_rst,
    input wire [1:0] i_rst_cause,
    // Register file access from the core
    input wire [4:0] i_addr,
    input wire i_wr_en,
    input wire [7:0] i_wr_data,
    input wire i_rd_en,
    input wire i_bit_op,
    input wire i_bit_val,
    input wire [2:0] i_bit_sel,
    input wire i_dir_load,
    input wire [2:0] i_dir_sel,
    input wire [7:0] i_accum,
    input wire i_sleep_enter,
    input wire i_sleeping,
    // Pins
    input wire [A_WIDTH-1:0] i_group_a_bits,
    output reg [A_WIDTH-1:0] o_group_a_bits,
    output reg [A_WIDTH-1:0] o_group_a_oe,
    input wire [B_WIDTH-1:0] i_group_b_bits,
    output reg [B_WIDTH-1:0] o_group_b_bits,
    output reg [B_WIDTH-1:0] o_group_b_oe,
    // Outputs to core and power logic
    output reg [7:0] o_rd_data,
    output reg o_wake_change_flag,
    output reg o_io_supply_level_select,
    output reg o_wake_reset_req
);

wire [A_WIDTH-1:0] pin_a_s;
wire [B_WIDTH-1:0] pin_b_s;
wire [7:0] pin_a_word;
wire [7:0] pin_b_word;
reg [A_WIDTH-1:0] latch_a_q;
reg [B_WIDTH-1:0] latch_b_q;
reg [A_WIDTH-1:0] pin_direction_a_q;
reg [B_WIDTH-1:0] pin_direction_b_q;
reg [5:0] extra_feature_config_q;
reg [3:0] wake_ref_q;
reg wake_d;
reg [7:0] bit_result;
wire [1:0] access_port;
wire [3:0] low_changed;
wire slow_high;

// ****************************************
// Pin synchronisers
// ****************************************
// Every pin passes two flops before any logic reads it
gpio_sync #(
    .WIDTH(A_WIDTH)
) u_sync_a (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_async(i_group_a_bits),
    .o_sync(pin_a_s)
);

gpio_sync #(
    .WIDTH(B_WIDTH)
) u_sync_b (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_async(i_group_b_bits),
    .o_sync(pin_b_s)
);

assign pin_a_word = {{(8-A_WIDTH){1'b0}}, pin_a_s};
assign pin_b_word = pin_b_s;

// ****************************************
// Address decode
// ****************************************
// Port latch hit by an access, bit 0 first port
function [1:0] port_decode;
    input [4:0] addr;
    begin
        port_decode = 2'h0;
        if (addr == `ADDR_GROUP_A)
        begin
            port_decode = 2'h1;
        end
        else if (addr == `ADDR_GROUP_B)
        begin
            port_decode = 2'h2;
        end
    end
endfunction

assign access_port = port_decode(i_addr);

// Set or clear one bit of a pin snapshot
function [7:0] bit_modify;
    input [7:0] word;
    input [2:0] sel;
    input val;
    reg [7:0] onehot;
    begin
        onehot = 8'h01 << sel;
        bit_modify = val ? (word | onehot) : (word & ~onehot);
    end
endfunction

always @*
begin
    bit_result = 8'h00;
    if (access_port[0])
    begin
        bit_result = bit_modify(pin_a_word, i_bit_sel, i_bit_val);
    end
    else
    begin
        bit_result = bit_modify(pin_b_word, i_bit_sel, i_bit_val);
    end
end

// ****************************************
// Output data latches
// ****************************************
// latches kept over reset
// No reset branch, so contents ride through soft resets
always @(posedge i_sys_clk)
begin
    if (i_bit_op && access_port[0])
    begin
        latch_a_q <= bit_result[A_WIDTH-1:0];
    end
    else if (i_wr_en && access_port[0])
    begin
        latch_a_q <= i_wr_data[A_WIDTH-1:0];
    end
    if (i_bit_op && access_port[1])
    begin
        latch_b_q <= bit_result[B_WIDTH-1:0];
    end
    else if (i_wr_en && access_port[1])
    begin
        latch_b_q <= i_wr_data[B_WIDTH-1:0];
    end
end

// ****************************************
// Direction and config registers
// ****************************************
always @(posedge i_sys_clk or negedge i_arst_n)
begin
    if (!i_arst_n)
    begin
        pin_direction_a_q <= {A_WIDTH{1'b1}};
        pin_direction_b_q <= {B_WIDTH{1'b1}};
        extra_feature_config_q <= `CFG_RESET;
    end
    // Soft reset wins over a direction load
    else if (i_soft_rst)
    begin
        pin_direction_a_q <= {A_WIDTH{1'b1}};
        pin_direction_b_q <= {B_WIDTH{1'b1}};
        if (i_rst_cause == `RST_POWER_ON)
        begin
            extra_feature_config_q <= `CFG_RESET;
        end
    end
    else if (i_dir_load)
    begin
        if (i_dir_sel == `DIR_SEL_A)
        begin
            pin_direction_a_q <= i_accum[A_WIDTH-1:0];
        end
        else if (i_dir_sel == `DIR_SEL_B)
        begin
            pin_direction_b_q <= i_accum[B_WIDTH-1:0];
        end
        else if (i_dir_sel == `DIR_SEL_CFG)
        begin
            extra_feature_config_q <= i_accum[5:0];
        end
    end
end

// ****************************************
// Wake-on-change
// ****************************************
// change from reference
assign low_changed = (pin_b_s[3:0] ^ wake_ref_q) & pin_direction_b_q[3:0];
assign slow_high = pin_b_s[`SLOW_PIN_BIT] & pin_direction_b_q[`SLOW_PIN_BIT];

always @*
begin
    wake_d = 1'b0;
    // single enable bit
    // Entry edge still holds the old reference
    if (i_sleeping && !i_sleep_enter && !extra_feature_config_q[`CFG_WAKE_DIS_BIT])
    begin
        if (|low_changed)
        begin
            wake_d = 1'b1;
        end
        if (slow_high)
        begin
            wake_d = 1'b1;
        end
    end
end

always @(posedge i_sys_clk or negedge i_arst_n)
begin
    if (!i_arst_n)
    begin
        wake_ref_q <= 4'h0;
        o_wake_reset_req <= 1'b0;
        o_wake_change_flag <= 1'b1;
    end
    else
    begin
        // Reference taken from synchronised pins
        // capture on sleep entry
        if (i_sleep_enter)
        begin
            wake_ref_q <= pin_b_s[3:0];
        end
        // Request drops in a soft reset cycle
        // wake request out
        o_wake_reset_req <= wake_d && !i_soft_rst;
        if (i_soft_rst)
        begin
            if (i_rst_cause == `RST_PIN_WAKE)
            begin
                o_wake_change_flag <= 1'b0;
            end
            else if (i_rst_cause != `RST_BROWN_OUT)
            begin
                o_wake_change_flag <= 1'b1;
            end
        end
    end
end

// ****************************************
// Pin drivers and read data
// ****************************************
always @(posedge i_sys_clk or negedge i_arst_n)
begin
    if (!i_arst_n)
    begin
        o_group_a_bits <= {A_WIDTH{1'b0}};
        o_group_a_oe <= {A_WIDTH{1'b0}};
        o_group_b_bits <= {B_WIDTH{1'b0}};
        o_group_b_oe <= {B_WIDTH{1'b0}};
        o_io_supply_level_select <= 1'b1;
        o_rd_data <= 8'h00;
    end
    else
    begin
        o_group_a_bits <= latch_a_q;
        o_group_a_oe <= ~pin_direction_a_q;
        o_group_b_bits <= latch_b_q;
        o_group_b_oe <= ~pin_direction_b_q;
        o_io_supply_level_select <= extra_feature_config_q[`CFG_SUPPLY_BIT];
        // Reads see the pins two cycles late
        if (i_rd_en)
        begin
            case (i_addr)
                `ADDR_GROUP_A: o_rd_data <= pin_a_word;
                `ADDR_GROUP_B: o_rd_data <= pin_b_word;
                `ADDR_CPU_FLAGS: o_rd_data <= {o_wake_change_flag, 7'h00};
                default: o_rd_data <= 8'h00;
            endcase
        end
    end
end

endmodule // gpio_port

`default_nettype wire

// ===== rtl/gpio_sync.v
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none

module gpio_sync #(
    parameter WIDTH = 8
) (
    input wire i_sys_clk,
    input wire i_arst_n,
    input wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);

reg [WIDTH-1:0] stage1_q;
reg [WIDTH-1:0] stage2_q;

always @(posedge i_sys_clk or negedge i_arst_n)
begin
    if (!i_arst_n)
    begin
        stage1_q <= {WIDTH{1'b0}};
        stage2_q <= {WIDTH{1'b0}};
    end
    else
    begin
        stage1_q <= i_async;
        stage2_q <= stage1_q;
    end
end

assign o_sync = stage2_q;

endmodule // gpio_sync

`default_nettype wire

// ===== testbench/board_model.sv
// Board circuitry model resolving pin levels
`timescale 1ns/1ps
`default_nettype none
module board_model (
    input wire logic [3:0] i_a_out,
    input wire logic [3:0] i_a_oe,
    input wire logic [3:0] i_a_ext,
    input wire logic [7:0] i_b_out,
    input wire logic [7:0] i_b_oe,
    input wire logic [7:0] i_b_ext,
    output logic [3:0] o_a_pin,
    output logic [7:0] o_b_pin
);
    // ********
    // Pins
    // ********
    // released pins held firm
    assign o_a_pin = (i_a_out & i_a_oe) | (i_a_ext & ~i_a_oe);
    assign o_b_pin = (i_b_out & i_b_oe) | (i_b_ext & ~i_b_oe);
endmodule // board_model
`default_nettype wire

// ===== testbench/gpio_port_assertions.sv
// Port checks for the GPIO block
`timescale 1ns/1ps
`default_nettype none
module gpio_port_assertions #(
    parameter A_WIDTH = 4,
    parameter B_WIDTH = 8
) (
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic i_soft_rst,
    input wire logic [1:0] i_rst_cause,
    input wire logic [4:0] i_addr,
    input wire logic i_rd_en,
    input wire logic i_dir_load,
    input wire logic [2:0] i_dir_sel,
    input wire logic [7:0] i_accum,
    input wire logic i_sleeping,
    input wire logic i_sleep_enter,
    input wire logic [B_WIDTH-1:0] i_group_b_bits,
    input wire logic [A_WIDTH-1:0] o_group_a_oe,
    input wire logic [B_WIDTH-1:0] o_group_b_oe,
    input wire logic [7:0] o_rd_data,
    input wire logic o_wake_change_flag,
    input wire logic o_io_supply_level_select,
    input wire logic o_wake_reset_req
);
    // ********
    // Checks
    // ********
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);
    sequence s_load(k);
        i_dir_load && i_dir_sel == k && !i_soft_rst;
    endsequence
    sequence s_idle;
        !i_dir_load && !i_soft_rst;
    endsequence
    AST_RST_INPUTS:
        assert property (i_soft_rst ##1 !i_dir_load |=> !(|o_group_a_oe) && !(|o_group_b_oe))
        else $error("oe after reset");
    AST_DIR_DRIVE:
        assert property (s_load(3'h6) ##1 s_idle |=> o_group_b_oe == ~$past(i_accum, 2))
        else $error("oe vs direction");
    AST_READ_PINS:
        assert property ($stable(i_group_b_bits)[*3] ##0 (i_rd_en && i_addr == 5'h06)
            |=> o_rd_data == $past(i_group_b_bits))
        else $error("read not pins");
    AST_A_UPPER:
        assert property (i_rd_en && i_addr == 5'h05 |=> o_rd_data[7:4] == 4'h0)
        else $error("upper bits set");
    AST_SUPPLY:
        assert property (s_load(3'h7) ##1 s_idle[*2]
            |=> o_io_supply_level_select == $past(i_accum[3], 3))
        else $error("supply select");
    AST_FLAG:
        assert property (i_soft_rst && i_rst_cause != 2'h3
            |=> o_wake_change_flag == ($past(i_rst_cause) != 2'h2))
        else $error("wake flag");
    AST_WAKE_SLEEP:
        assert property ($rose(o_wake_reset_req) |-> $past(i_sleeping))
        else $error("wake while awake");
    AST_NO_OUT_WAKE:
        assert property ((&o_group_b_oe)[*4] |-> !$rose(o_wake_reset_req))
        else $error("output pin woke");
    AST_ENTRY_QUIET:
        assert property (i_sleep_enter |=> !o_wake_reset_req)
        else $error("wake on sleep entry");
endmodule // gpio_port_assertions
bind gpio_port gpio_port_assertions #(.A_WIDTH(A_WIDTH), .B_WIDTH(B_WIDTH)) chk_u (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_soft_rst(i_soft_rst),
    .i_rst_cause(i_rst_cause),
    .i_addr(i_addr),
    .i_rd_en(i_rd_en),
    .i_dir_load(i_dir_load),
    .i_dir_sel(i_dir_sel),
    .i_accum(i_accum),
    .i_sleeping(i_sleeping),
    .i_sleep_enter(i_sleep_enter),
    .i_group_b_bits(i_group_b_bits),
    .o_group_a_oe(o_group_a_oe),
    .o_group_b_oe(o_group_b_oe),
    .o_rd_data(o_rd_data),
    .o_wake_change_flag(o_wake_change_flag),
    .o_io_supply_level_select(o_io_supply_level_select),
    .o_wake_reset_req(o_wake_reset_req)
);
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench for the GPIO block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic i_sys_clk = 0, i_arst_n = 0, i_soft_rst = 0, i_wr_en = 0, i_rd_en = 0;
    logic i_bit_op = 0, i_bit_val = 0, i_dir_load = 0, i_sleep_enter = 0, i_sleeping = 0;
    logic [1:0] i_rst_cause = 0;
    logic [2:0] i_bit_sel = 0, i_dir_sel = 0;
    logic [4:0] i_addr = 0;
    logic [7:0] i_wr_data = 0, i_accum = 0, ext_b = 0, rd, pin_b, out_b, oe_b, o_rd_data;
    logic [3:0] ext_a = 0, pin_a, out_a, oe_a;
    logic flag, sup, req;
    int n_errors = 0, checked = 0;
    // Direction, latch, pins, expected read
    logic [31:0] rows [4] = '{32'hff00a5a5, 32'h003cff3c, 32'h0f5ac353, 32'hf0960f06};
    gpio_port dut_u (.i_sys_clk, .i_arst_n, .i_soft_rst, .i_rst_cause, .i_addr, .i_wr_en,
        .i_wr_data, .i_rd_en, .i_bit_op, .i_bit_val, .i_bit_sel, .i_dir_load, .i_dir_sel,
        .i_accum, .i_sleep_enter, .i_sleeping, .i_group_a_bits(pin_a), .o_group_a_bits(out_a),
        .o_group_a_oe(oe_a), .i_group_b_bits(pin_b), .o_group_b_bits(out_b),
        .o_group_b_oe(oe_b), .o_rd_data, .o_wake_change_flag(flag),
        .o_io_supply_level_select(sup), .o_wake_reset_req(req));
    board_model brd_u (.i_a_out(out_a), .i_a_oe(oe_a), .i_a_ext(ext_a), .i_b_out(out_b),
        .i_b_oe(oe_b), .i_b_ext(ext_b), .o_a_pin(pin_a), .o_b_pin(pin_b));
    always #4 i_sys_clk = ~i_sys_clk;
    // ********
    // Tasks
    // ********
    task chk(input logic [7:0] s, input logic [7:0] e);
        checked++;
        if (s !== e)
        begin
            n_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task end_sim;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Kind 0 write, 1 read, 2 direction load, 3 bit op
    task op(input int k, input logic [4:0] a, input logic [7:0] d);
        repeat (4) @(posedge i_sys_clk);
        i_addr <= a;
        i_wr_data <= d;
        i_accum <= d;
        i_dir_sel <= a[2:0];
        i_bit_val <= d[3];
        i_bit_sel <= d[2:0];
        i_wr_en <= (k == 0);
        i_rd_en <= (k == 1);
        i_dir_load <= (k == 2);
        i_bit_op <= (k == 3);
        @(posedge i_sys_clk);
        {i_wr_en, i_rd_en, i_dir_load, i_bit_op} <= 4'h0;
        repeat (3) @(posedge i_sys_clk);
        rd = o_rd_data;
    endtask
    task rst(input logic [1:0] c);
        @(posedge i_sys_clk);
        i_soft_rst <= 1;
        i_rst_cause <= c;
        i_sleeping <= 0;
        @(posedge i_sys_clk);
        i_soft_rst <= 0;
        repeat (3) @(posedge i_sys_clk);
    endtask
    // Sleep, move pins and latch B, note the wake request, then wake reset
    task slp(input logic [7:0] e, input logic [7:0] w);
        @(posedge i_sys_clk);
        i_sleep_enter <= 1;
        i_sleeping <= 1;
        @(posedge i_sys_clk);
        i_sleep_enter <= 0;
        repeat (4) @(posedge i_sys_clk);
        ext_b <= e;
        i_addr <= 5'h06;
        i_wr_data <= w;
        i_wr_en <= 1;
        @(posedge i_sys_clk);
        i_wr_en <= 0;
        repeat (5) @(posedge i_sys_clk);
        rd = {7'h0, req};
        ext_b <= 8'h05;
        rst(2);
    endtask
    initial
    begin
        #400000;
        n_errors++;
        end_sim;
    end
    initial
    begin
        repeat (20) @(posedge i_sys_clk);
        i_arst_n <= 1;
        chk(oe_b, 8'h00);
        chk(flag, 8'h01);
        chk(sup, 8'h01);
        op(1, 3, 0);
        chk(rd, 8'h80);
        $display("test reset done");
        foreach (rows[i])
        begin
            op(2, 6, rows[i][31:24]);
            op(0, 6, rows[i][23:16]);
            ext_b <= rows[i][15:8];
            op(1, 6, 0);
            chk(rd, rows[i][7:0]);
            chk(oe_b, ~rows[i][31:24]);
        end
        $display("test rows done");
        op(2, 5, 8'h00);
        op(0, 5, 8'hf9);
        op(1, 5, 0);
        chk(rd, 8'h09);
        op(2, 6, 8'hfe);
        op(0, 6, 8'h00);
        ext_b <= 8'h03;
        op(3, 6, 8'h0d);
        op(2, 6, 8'h00);
        chk(out_b, 8'h22);
        op(0, 6, 8'h3c);
        rst(1);
        chk(out_b, 8'h3c);
        chk(flag, 8'h01);
        chk(oe_b, 8'h00);
        $display("test latch done");
        op(2, 7, 8'h17);
        chk(sup, 8'h00);
        ext_b <= 8'h05;
        op(2, 6, 8'hff);
        slp(8'h07, 8'h3c);
        chk(rd, 8'h01);
        chk(flag, 8'h00);
        rst(3);
        chk(flag, 8'h00);
        slp(8'h85, 8'h3c);
        chk(rd, 8'h01);
        op(2, 6, 8'h00);
        slp(8'h07, 8'h8f);
        chk(rd, 8'h00);
        op(2, 6, 8'hff);
        op(2, 7, 8'h3f);
        chk(sup, 8'h01);
        slp(8'h87, 8'h3c);
        chk(rd, 8'h00);
        rst(1);
        chk(flag, 8'h01);
        op(2, 7, 8'h17);
        rst(0);
        chk(sup, 8'h01);
        $display("test wake done");
        end_sim;
    end
endmodule // tb_top
`default_nettype wire
